// ===== ecm_map.svh
// register offsets, field positions and timing counts of the clock/misc block
`ifndef ECM_MAP_SVH
`define ECM_MAP_SVH
`define ECM_ADDR_DATA_B 8'h10
`define ECM_ADDR_DATA_A 8'h11
`define ECM_ADDR_ISRC_B 8'h18
`define ECM_ADDR_ISRC_A 8'h19
`define ECM_ADDR_EVT_B 8'h1a
`define ECM_ADDR_EVT_A 8'h1b
`define ECM_ADDR_LS_LOW 8'h1d
`define ECM_ADDR_OSC 8'h1e
`define ECM_ADDR_MISC 8'h1f
`define ECM_ADDR_LED_EN_B 8'h20
`define ECM_RST_CFG 8'h00
`define ECM_LS_OFF 2'h0
`define ECM_LS_A2B 2'h1
`define ECM_LS_B2A 2'h2
`define ECM_OSC_SRC_HI 6
`define ECM_OSC_SRC_LO 5
`define ECM_OSC_DIR_BIT 4
`define ECM_OSC_OUT_HI 3
`define ECM_OSC_OUT_LO 0
`define ECM_OSC_OUT_LOW 4'h0
`define ECM_OSC_OUT_HIGH 4'hf
`define ECM_MISC_LOG_B_BIT 7
`define ECM_MISC_LED_HI 6
`define ECM_MISC_LED_LO 4
`define ECM_MISC_LOG_A_BIT 3
`define ECM_MISC_RST_FN_BIT 2
`define ECM_MISC_AUTOINC_BIT 1
`define ECM_MISC_AUTOCLR_BIT 0
`define ECM_CLK_SYS_NS 4
`define ECM_INT_OSC_NS 500
`define ECM_INT_OSC_CYC (`ECM_INT_OSC_NS / `ECM_CLK_SYS_NS)
`define ECM_INT_OSC_HALF (`ECM_INT_OSC_CYC / 2)
`define ECM_DIV_W 13
`endif

// ===== ecm_pkg.sv
// types shared by the clock/misc configuration block
package ecm_pkg;
	typedef enum logic [1:0] {
		ECM_OSC_OFF,
		ECM_OSC_EXT,
		ECM_OSC_INT,
		ECM_OSC_RSVD
	} ecm_osc_src_e;
	typedef struct packed {
		logic start;
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} ecm_reg_req_s;
	typedef struct packed {
		logic [3:0] a_to_b;
		logic [3:0] b_to_a;
	} ecm_ls_s;
	typedef struct packed {
		logic led_drive_en;
		logic log_bank_a;
		logic log_bank_b;
		logic [7:0] enable_upper;
	} ecm_led_s;
endpackage

// ===== ecm_clk_div.sv
// power-of-two divider of the oscillator: code 1 passes it, code n divides by 2^(n-1)
`include "ecm_map.svh"
module ecm_clk_div (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic osc_level,
	input wire logic osc_tick,
	input wire logic [3:0] code,
	output logic clk_out
);
	logic [`ECM_DIV_W-1:0] cnt_reg;
	logic [`ECM_DIV_W-1:0] cnt_next;
	logic clk_out_next;

	always_comb begin
		cnt_next = cnt_reg;
		if (osc_tick) begin
			cnt_next = cnt_reg + `ECM_DIV_W'(1);
		end
		// counter bit k has period 2^(k+1) oscillator cycles
		if (code == 4'h0) begin
			clk_out_next = 1'b0;
		end else if (code == 4'h1) begin
			clk_out_next = osc_level;
		end else begin
			clk_out_next = cnt_reg[code - 4'h2];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
			clk_out <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			clk_out <= clk_out_next;
		end
	end
endmodule

// ===== ecm_top.sv
// clock source, divided clock pin, led clock, level shifters and misc control
`include "ecm_map.svh"
module ecm_top (
	input wire logic clk_sys,
	input wire logic rst_b,
	input ecm_pkg::ecm_reg_req_s reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [15:0] pin_data,
	input wire logic [15:0] pin_event,
	input wire logic [15:0] interrupt_mask,
	input wire logic external_reset_pin,
	input wire logic oscillator_pin_input,
	output logic oscillator_pin_output,
	output logic oscillator_pin_oe,
	output ecm_pkg::ecm_ls_s level_shift,
	output ecm_pkg::ecm_led_s led_ctrl,
	output logic led_clock,
	output logic osc_running,
	output logic keypad_enable,
	output logic debounce_enable,
	output logic led_counters_reset,
	output logic interrupt_out_n
);
	import ecm_pkg::*;

	function automatic logic [7:0] set_clr(input logic [7:0] cur,
			input logic [7:0] set, input logic [7:0] clr);
		// set wins over a clear in the same cycle
		set_clr = (cur & ~clr) | set;
	endfunction

	////////////////////////////////////////////////////////////////////
	// pin synchronisers: three stages, level taken when stages 2 and 3 agree
	logic [2:0] rst_sync_reg;
	logic [2:0] rst_sync_next;
	logic rst_pin_reg;
	logic rst_pin_next;
	logic [2:0] osc_sync_reg;
	logic [2:0] osc_sync_next;
	logic osc_ext_reg;
	logic osc_ext_next;

	always_comb begin
		rst_sync_next = {rst_sync_reg[1:0], external_reset_pin};
		osc_sync_next = {osc_sync_reg[1:0], oscillator_pin_input};
		rst_pin_next = rst_pin_reg;
		osc_ext_next = osc_ext_reg;
		if (rst_sync_reg[1] == rst_sync_reg[2]) begin
			rst_pin_next = rst_sync_reg[2];
		end
		if (osc_sync_reg[1] == osc_sync_reg[2]) begin
			osc_ext_next = osc_sync_reg[2];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_reg <= 3'h7;
			rst_pin_reg <= 1'b1;
			osc_sync_reg <= 3'h0;
			osc_ext_reg <= 1'b0;
		end else begin
			rst_sync_reg <= rst_sync_next;
			rst_pin_reg <= rst_pin_next;
			osc_sync_reg <= osc_sync_next;
			osc_ext_reg <= osc_ext_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// configuration registers and address pointer
	logic [7:0] ls_low_reg;
	logic [7:0] ls_low_next;
	logic [7:0] osc_cfg_reg;
	logic [7:0] osc_cfg_next;
	logic [7:0] misc_reg;
	logic [7:0] misc_next;
	logic [7:0] led_en_b_reg;
	logic [7:0] led_en_b_next;
	logic [7:0] ptr_reg;
	logic [7:0] ptr_next;
	logic [7:0] rdata_next;
	logic rvalid_next;
	logic [15:0] isrc_reg;
	logic [15:0] isrc_next;
	logic [15:0] evt_reg;
	logic [15:0] evt_next;
	logic soft_por;
	logic access;
	logic [15:0] clr_isrc;
	logic [15:0] clr_evt;
	logic [15:0] new_evt;

	always_comb begin
		// pin low with function bit 0 acts like power-on reset
		soft_por = !rst_pin_reg && !misc_reg[`ECM_MISC_RST_FN_BIT];
		access = reg_req.wr || reg_req.rd;
		ls_low_next = ls_low_reg;
		osc_cfg_next = osc_cfg_reg;
		misc_next = misc_reg;
		led_en_b_next = led_en_b_reg;
		ptr_next = ptr_reg;
		rdata_next = reg_rdata;
		// a read in a start cycle is ignored and returns no data
		rvalid_next = reg_req.rd && !reg_req.start;
		clr_isrc = '0;
		clr_evt = '0;
		if (reg_req.start) begin
			ptr_next = reg_req.addr;
		end else if (access) begin
			if (!misc_reg[`ECM_MISC_AUTOINC_BIT]) begin
				ptr_next = ptr_reg + 8'h01;
			end
		end
		if (reg_req.wr && !reg_req.start) begin
			if (ptr_reg == `ECM_ADDR_LS_LOW) begin
				ls_low_next = reg_req.wdata;
			end else if (ptr_reg == `ECM_ADDR_OSC) begin
				osc_cfg_next = reg_req.wdata;
			end else if (ptr_reg == `ECM_ADDR_MISC) begin
				misc_next = reg_req.wdata;
			end else if (ptr_reg == `ECM_ADDR_LED_EN_B) begin
				led_en_b_next = reg_req.wdata;
			end else if (ptr_reg == `ECM_ADDR_ISRC_B) begin
				clr_isrc[15:8] = reg_req.wdata;
				clr_evt[15:8] = reg_req.wdata;
			end else if (ptr_reg == `ECM_ADDR_ISRC_A) begin
				clr_isrc[7:0] = reg_req.wdata;
				clr_evt[7:0] = reg_req.wdata;
			end else if (ptr_reg == `ECM_ADDR_EVT_B) begin
				clr_evt[15:8] = reg_req.wdata;
				clr_isrc[15:8] = reg_req.wdata;
			end else if (ptr_reg == `ECM_ADDR_EVT_A) begin
				clr_evt[7:0] = reg_req.wdata;
				clr_isrc[7:0] = reg_req.wdata;
			end
		end
		if (reg_req.rd && !reg_req.start) begin
			if (ptr_reg == `ECM_ADDR_DATA_B) begin
				rdata_next = pin_data[15:8];
				if (!misc_reg[`ECM_MISC_AUTOCLR_BIT]) begin
					clr_isrc[15:8] = 8'hff;
				end
			end else if (ptr_reg == `ECM_ADDR_DATA_A) begin
				rdata_next = pin_data[7:0];
				if (!misc_reg[`ECM_MISC_AUTOCLR_BIT]) begin
					clr_isrc[7:0] = 8'hff;
				end
			end else if (ptr_reg == `ECM_ADDR_ISRC_B) begin
				rdata_next = isrc_reg[15:8];
			end else if (ptr_reg == `ECM_ADDR_ISRC_A) begin
				rdata_next = isrc_reg[7:0];
			end else if (ptr_reg == `ECM_ADDR_EVT_B) begin
				rdata_next = evt_reg[15:8];
			end else if (ptr_reg == `ECM_ADDR_EVT_A) begin
				rdata_next = evt_reg[7:0];
			end else if (ptr_reg == `ECM_ADDR_LS_LOW) begin
				rdata_next = ls_low_reg;
			end else if (ptr_reg == `ECM_ADDR_OSC) begin
				rdata_next = osc_cfg_reg;
			end else if (ptr_reg == `ECM_ADDR_MISC) begin
				rdata_next = misc_reg;
			end else if (ptr_reg == `ECM_ADDR_LED_EN_B) begin
				rdata_next = led_en_b_reg;
			end else begin
				rdata_next = 8'h00;
			end
		end
		new_evt = pin_event;
		evt_next[15:8] = set_clr(evt_reg[15:8], new_evt[15:8], clr_evt[15:8]);
		evt_next[7:0] = set_clr(evt_reg[7:0], new_evt[7:0], clr_evt[7:0]);
		isrc_next[15:8] = set_clr(isrc_reg[15:8],
			new_evt[15:8] & ~interrupt_mask[15:8], clr_isrc[15:8]);
		isrc_next[7:0] = set_clr(isrc_reg[7:0],
			new_evt[7:0] & ~interrupt_mask[7:0], clr_isrc[7:0]);
		if (soft_por) begin
			// the function bit itself is 0 here, so it stays 0
			ls_low_next = `ECM_RST_CFG;
			osc_cfg_next = `ECM_RST_CFG;
			misc_next = `ECM_RST_CFG;
			led_en_b_next = `ECM_RST_CFG;
			isrc_next = '0;
			evt_next = '0;
			ptr_next = 8'h00;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ls_low_reg <= `ECM_RST_CFG;
			osc_cfg_reg <= `ECM_RST_CFG;
			misc_reg <= `ECM_RST_CFG;
			led_en_b_reg <= `ECM_RST_CFG;
			ptr_reg <= 8'h00;
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
			isrc_reg <= '0;
			evt_reg <= '0;
		end else begin
			ls_low_reg <= ls_low_next;
			osc_cfg_reg <= osc_cfg_next;
			misc_reg <= misc_next;
			led_en_b_reg <= led_en_b_next;
			ptr_reg <= ptr_next;
			reg_rdata <= rdata_next;
			reg_rvalid <= rvalid_next;
			isrc_reg <= isrc_next;
			evt_reg <= evt_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// oscillator source, internal 2 MHz from the system clock
	ecm_osc_src_e osc_src;
	logic [7:0] int_cnt_reg;
	logic [7:0] int_cnt_next;
	logic int_lvl_reg;
	logic int_lvl_next;
	logic osc_lvl_reg;
	logic osc_lvl_next;
	logic osc_level;
	logic osc_tick;

	always_comb begin
		osc_src = ecm_osc_src_e'(osc_cfg_reg[`ECM_OSC_SRC_HI:`ECM_OSC_SRC_LO]);
		int_cnt_next = int_cnt_reg + 8'h01;
		int_lvl_next = int_lvl_reg;
		if (int_cnt_reg == 8'(`ECM_INT_OSC_CYC - 1)) begin
			int_cnt_next = 8'h00;
			int_lvl_next = 1'b1;
		end else if (int_cnt_reg == 8'(`ECM_INT_OSC_HALF - 1)) begin
			int_lvl_next = 1'b0;
		end
		// reserved and off codes stop the oscillator
		case (osc_src)
		ECM_OSC_EXT: osc_level = osc_ext_reg;
		ECM_OSC_INT: osc_level = int_lvl_reg;
		default: osc_level = 1'b0;
		endcase
		osc_lvl_next = osc_level;
		osc_tick = osc_level && !osc_lvl_reg;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			int_cnt_reg <= 8'h00;
			int_lvl_reg <= 1'b0;
			osc_lvl_reg <= 1'b0;
		end else begin
			int_cnt_reg <= int_cnt_next;
			int_lvl_reg <= int_lvl_next;
			osc_lvl_reg <= osc_lvl_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// divided clock pin and led clock
	logic [3:0] out_code;
	logic [3:0] led_code;
	logic div_out;
	logic led_div;
	logic pin_out_next;
	logic pin_oe_next;
	logic osc_on;

	always_comb begin
		out_code = osc_cfg_reg[`ECM_OSC_OUT_HI:`ECM_OSC_OUT_LO];
		led_code = {1'b0, misc_reg[`ECM_MISC_LED_HI:`ECM_MISC_LED_LO]};
		osc_on = (osc_src == ECM_OSC_EXT) || (osc_src == ECM_OSC_INT);
		// the direction bit alone sets the output enable; the external source still samples the pin input
		pin_oe_next = osc_cfg_reg[`ECM_OSC_DIR_BIT];
		if (out_code == `ECM_OSC_OUT_LOW) begin
			pin_out_next = 1'b0;
		end else if (out_code == `ECM_OSC_OUT_HIGH) begin
			pin_out_next = 1'b1;
		end else begin
			pin_out_next = div_out;
		end
		if (!pin_oe_next) begin
			pin_out_next = 1'b0;
		end
	end

	ecm_clk_div u_out_div (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.osc_level(osc_level),
		.osc_tick(osc_tick),
		.code(out_code),
		.clk_out(div_out)
	);

	ecm_clk_div u_led_div (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.osc_level(osc_level),
		.osc_tick(osc_tick),
		.code(led_code),
		.clk_out(led_div)
	);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			oscillator_pin_output <= 1'b0;
			oscillator_pin_oe <= 1'b0;
			led_clock <= 1'b0;
			osc_running <= 1'b0;
			keypad_enable <= 1'b0;
			debounce_enable <= 1'b0;
			led_counters_reset <= 1'b0;
			level_shift <= '0;
			led_ctrl <= '0;
			interrupt_out_n <= 1'b1;
		end else begin
			oscillator_pin_output <= pin_out_next;
			oscillator_pin_oe <= pin_oe_next;
			led_clock <= led_div;
			osc_running <= osc_on;
			keypad_enable <= osc_on;
			debounce_enable <= osc_on;
			led_counters_reset <= !rst_pin_reg
				&& misc_reg[`ECM_MISC_RST_FN_BIT];
			for (int i = 0; i < 4; i++) begin
				// reserved pair code drives neither way
				level_shift.a_to_b[i] <=
					ls_low_reg[2*i +: 2] == `ECM_LS_A2B;
				level_shift.b_to_a[i] <=
					ls_low_reg[2*i +: 2] == `ECM_LS_B2A;
			end
			led_ctrl.led_drive_en <= osc_on && (led_code != 4'h0);
			led_ctrl.log_bank_b <= misc_reg[`ECM_MISC_LOG_B_BIT];
			led_ctrl.log_bank_a <= misc_reg[`ECM_MISC_LOG_A_BIT];
			led_ctrl.enable_upper <= led_en_b_reg;
			interrupt_out_n <= !(|isrc_next);
		end
	end
endmodule

// ===== ecm_chk.sv
// port-level checker of the clock/misc configuration block
module ecm_chk (
	input wire logic clk_sys,
	input wire logic rst_b,
	input ecm_pkg::ecm_reg_req_s reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic [15:0] pin_event,
	input wire logic [15:0] interrupt_mask,
	input wire logic external_reset_pin,
	input wire logic oscillator_pin_output,
	input wire logic oscillator_pin_oe,
	input ecm_pkg::ecm_ls_s level_shift,
	input ecm_pkg::ecm_led_s led_ctrl,
	input wire logic osc_running,
	input wire logic keypad_enable,
	input wire logic debounce_enable,
	input wire logic led_counters_reset,
	input wire logic interrupt_out_n
);
	import ecm_pkg::*;
	logic ev_hit;
	assign ev_hit = |(pin_event & ~interrupt_mask);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////
	a_osc_gates_all: assert property (
		keypad_enable == osc_running && debounce_enable == osc_running)
		else $error("keypad or debounce enable differs from osc");
	a_led_needs_osc: assert property (
		led_ctrl.led_drive_en |-> osc_running || $past(osc_running))
		else $error("led drive enabled without oscillator");
	a_gpo_idle_low: assert property (
		!oscillator_pin_oe |-> !oscillator_pin_output)
		else $error("osc pin driven while not enabled");
	a_shift_one_way: assert property (
		(level_shift.a_to_b & level_shift.b_to_a) == 4'h0)
		else $error("level shifter pair driven both ways");
	a_read_answer: assert property (
		reg_rvalid == $past(reg_req.rd && !reg_req.start))
		else $error("read valid not one cycle after read");
	a_rdata_holds: assert property (
		$changed(reg_rdata) |-> reg_rvalid || !external_reset_pin)
		else $error("read data changed without a read");
	a_cnt_reset_cause: assert property (
		$rose(led_counters_reset) |-> !$past(external_reset_pin, 3))
		else $error("counter reset without reset pin low");
	a_irq_on_event: assert property (
		ev_hit |-> ##[1:3] !interrupt_out_n)
		else $error("unmasked event raised no interrupt");
	a_irq_has_cause: assert property (
		$fell(interrupt_out_n) |->
		$past(ev_hit) || $past(ev_hit, 2) || $past(ev_hit, 3))
		else $error("interrupt without unmasked event");
	c_read: cover property (reg_rvalid);
	c_irq: cover property ($fell(interrupt_out_n));
	c_cnt_reset: cover property ($rose(led_counters_reset));
endmodule

// ===== ecm_host.sv
// host controller model driving the register request port
module ecm_host (
	input wire logic clk_sys,
	output ecm_pkg::ecm_reg_req_s reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	import ecm_pkg::*;
	initial reg_req = '0;
	// one assignment per edge, so back to back requests never collide
	task automatic op(input logic s, w, r, input logic [7:0] a, d);
		@(posedge clk_sys);
		reg_req <= '{start: s, addr: a, wr: w, rd: r, wdata: d};
	endtask
	// read at the pointer; answer sampled after the edge that launches it
	task automatic rd(output logic [8:0] got);
		op(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
		op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
		#1;
		got = {reg_rvalid, reg_rdata};
	endtask
endmodule

// ===== tb_top.sv
// self-checking bench of the clock/misc configuration block
`include "ecm_map.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ecm_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [15:0] pin_data = 16'h5aa5;
	logic [15:0] pin_event = 16'h0000;
	logic [15:0] interrupt_mask = 16'h0002;
	logic external_reset_pin = 1'b1;
	logic oscillator_pin_input = 1'b0;
	ecm_reg_req_s reg_req;
	logic [7:0] reg_rdata;
	logic reg_rvalid, oscillator_pin_output, oscillator_pin_oe, led_clock;
	logic osc_running, keypad_enable, debounce_enable;
	logic led_counters_reset, interrupt_out_n;
	ecm_ls_s level_shift;
	ecm_led_s led_ctrl;
	int n_fail = 0;
	int checks_done = 0;
	int rc, lc, e;
	logic po, pl;
	logic [8:0] got;
	initial forever #2 clk_sys = ~clk_sys;
	// external clock source: 25 mhz, free running
	initial forever #20 oscillator_pin_input = ~oscillator_pin_input;
	ecm_host u_host (.clk_sys(clk_sys), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	ecm_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.pin_data(pin_data), .pin_event(pin_event),
		.interrupt_mask(interrupt_mask),
		.external_reset_pin(external_reset_pin),
		.oscillator_pin_input(oscillator_pin_input),
		.oscillator_pin_output(oscillator_pin_output),
		.oscillator_pin_oe(oscillator_pin_oe), .level_shift(level_shift),
		.led_ctrl(led_ctrl), .led_clock(led_clock),
		.osc_running(osc_running), .keypad_enable(keypad_enable),
		.debounce_enable(debounce_enable),
		.led_counters_reset(led_counters_reset),
		.interrupt_out_n(interrupt_out_n));
	////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (n_fail == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, x);
		checks_done++;
		if (g !== x) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) u_host.op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
	endtask
	task automatic put(input logic [7:0] a, d);
		u_host.op(1'b1, 1'b0, 1'b0, a, 8'h00);
		u_host.op(1'b0, 1'b1, 1'b0, 8'h00, d);
		idle(3);
	endtask
	task automatic get(input logic [7:0] a, x);
		u_host.op(1'b1, 1'b0, 1'b0, a, 8'h00);
		u_host.rd(got);
		chk({7'h0, got}, {8'h01, x});
	endtask
	task automatic ev(input int i);
		@(posedge clk_sys);
		pin_event <= 16'h0001 << i;
		@(posedge clk_sys);
		pin_event <= 16'h0000;
		idle(4);
	endtask
	task automatic pin_rst(input logic x);
		@(posedge clk_sys);
		external_reset_pin <= 1'b0;
		repeat (10) @(posedge clk_sys);
		chk({15'h0, led_counters_reset}, {15'h0, x});
		external_reset_pin <= 1'b1;
		idle(8);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		n_fail++;
		print_verdict();
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		idle(2);
		chk({15'h0, interrupt_out_n}, 16'h0001);
		for (int a = 8'h1d; a <= 8'h20; a++)
			get(8'(a), `ECM_RST_CFG);
		put(8'h40, 8'hff);
		get(8'h40, 8'h00);
		// burst of three bytes walks the pointer across three registers
		u_host.op(1'b1, 1'b0, 1'b0, `ECM_ADDR_LS_LOW, 8'h00);
		u_host.op(1'b0, 1'b1, 1'b0, 8'h00, 8'he4);
		u_host.op(1'b0, 1'b1, 1'b0, 8'h00, 8'h10);
		u_host.op(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
		idle(3);
		chk({8'h0, level_shift}, 16'h0024);
		chk({14'h0, oscillator_pin_oe, oscillator_pin_output}, 2);
		get(`ECM_ADDR_OSC, 8'h10);
		put(`ECM_ADDR_LS_LOW, 8'h1b);
		chk({8'h0, level_shift}, 16'h0042);
		put(`ECM_ADDR_OSC, 8'h1f);
		chk({14'h0, oscillator_pin_oe, oscillator_pin_output}, 3);
		put(`ECM_ADDR_OSC, 8'h0f);
		chk({14'h0, oscillator_pin_oe, oscillator_pin_output}, 0);
		put(`ECM_ADDR_MISC, 8'h10);
		for (int s = 0; s < 4; s++) begin
			put(`ECM_ADDR_OSC, 8'(s << 5));
			e = (s == 1 || s == 2) ? 15 : 0;
			chk({12'h0, osc_running, keypad_enable, debounce_enable,
				led_ctrl.led_drive_en}, 16'(e));
		end
		for (int n = 1; n < 4; n++) begin
			put(`ECM_ADDR_OSC, 8'(8'h30 | n));
			put(`ECM_ADDR_MISC, 8'(n << 4));
			repeat (40) @(negedge clk_sys);
			rc = 0;
			lc = 0;
			po = oscillator_pin_output;
			pl = led_clock;
			repeat (640) begin
				@(negedge clk_sys);
				rc += (oscillator_pin_output && !po) ? 1 : 0;
				lc += (led_clock && !pl) ? 1 : 0;
				po = oscillator_pin_output;
				pl = led_clock;
			end
			e = 64 >> (n - 1);
			chk(16'(rc >= e - 1 && rc <= e + 1), 16'h0001);
			chk(16'(lc >= e - 1 && lc <= e + 1), 16'h0001);
		end
		put(`ECM_ADDR_MISC, 8'h88);
		chk({14'h0, led_ctrl.log_bank_b, led_ctrl.log_bank_a}, 3);
		put(`ECM_ADDR_MISC, 8'h08);
		chk({14'h0, led_ctrl.log_bank_b, led_ctrl.log_bank_a}, 1);
		put(`ECM_ADDR_LED_EN_B, 8'h3c);
		chk({8'h0, led_ctrl.enable_upper}, 16'h003c);
		// fixed pointer: the second byte lands on the same register
		put(`ECM_ADDR_MISC, 8'h12);
		u_host.op(1'b1, 1'b0, 1'b0, `ECM_ADDR_LED_EN_B, 8'h00);
		u_host.op(1'b0, 1'b1, 1'b0, 8'h00, 8'h11);
		u_host.op(1'b0, 1'b1, 1'b0, 8'h00, 8'h22);
		u_host.rd(got);
		chk({7'h0, got}, 16'h0122);
		u_host.rd(got);
		chk({7'h0, got}, 16'h0122);
		put(`ECM_ADDR_MISC, 8'h14);
		pin_rst(1'b1);
		get(`ECM_ADDR_MISC, 8'h14);
		get(`ECM_ADDR_LED_EN_B, 8'h22);
		put(`ECM_ADDR_MISC, 8'h00);
		pin_rst(1'b0);
		get(`ECM_ADDR_LED_EN_B, 8'h00);
		get(`ECM_ADDR_OSC, 8'h00);
		ev(0);
		chk({15'h0, interrupt_out_n}, 16'h0000);
		get(`ECM_ADDR_ISRC_A, 8'h01);
		get(`ECM_ADDR_DATA_A, 8'ha5);
		idle(3);
		get(`ECM_ADDR_ISRC_A, 8'h00);
		chk({15'h0, interrupt_out_n}, 16'h0001);
		ev(9);
		get(`ECM_ADDR_ISRC_B, 8'h02);
		get(`ECM_ADDR_EVT_B, 8'h02);
		put(`ECM_ADDR_ISRC_B, 8'h02);
		get(`ECM_ADDR_EVT_B, 8'h00);
		chk({15'h0, interrupt_out_n}, 16'h0001);
		ev(1);
		chk({15'h0, interrupt_out_n}, 16'h0001);
		// bit 0 is still set from the first event: a data read clears only sources
		get(`ECM_ADDR_EVT_A, 8'h03);
		put(`ECM_ADDR_EVT_A, 8'h03);
		put(`ECM_ADDR_MISC, 8'h01);
		ev(2);
		get(`ECM_ADDR_DATA_A, 8'ha5);
		idle(3);
		get(`ECM_ADDR_ISRC_A, 8'h04);
		put(`ECM_ADDR_ISRC_A, 8'h04);
		chk({15'h0, interrupt_out_n}, 16'h0001);
		print_verdict();
	end
endmodule
bind ecm_top ecm_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
	.reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.pin_event(pin_event), .interrupt_mask(interrupt_mask),
	.external_reset_pin(external_reset_pin),
	.oscillator_pin_output(oscillator_pin_output),
	.oscillator_pin_oe(oscillator_pin_oe), .level_shift(level_shift),
	.led_ctrl(led_ctrl), .osc_running(osc_running),
	.keypad_enable(keypad_enable), .debounce_enable(debounce_enable),
	.led_counters_reset(led_counters_reset),
	.interrupt_out_n(interrupt_out_n));
